// ### watchdog_pkg.sv
/*
  Constants shared by the watchdog countdown unit and its tick divider.
  Assumes a 100 MHz system clock and byte-wide software write strobes.
*/
package watchdog_pkg;

    localparam int          CLOCK_PERIOD_NS   = 10;
    // Period of the dedicated low-rate oscillator tick
    localparam int          OSC_PERIOD_NS     = 10000;
    localparam int          OSC_TICK_CYCLES   = OSC_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam int          OSC_COUNT_WIDTH   = 10;

    localparam logic [7:0]  UNLOCK_FIRST      = 8'h55;
    localparam logic [7:0]  UNLOCK_SECOND     = 8'hAA;

    localparam int          COUNT_WIDTH       = 24;
    localparam logic [23:0] COUNT_TERMINAL    = 24'h000000;
    localparam logic [23:0] RELOAD_RESET      = 24'hFFFFFF;

    localparam int          BYTE_LOW_POS      = 0;
    localparam int          BYTE_HIGH_POS     = 8;
    localparam int          BYTE_UPPER_POS    = 16;

    typedef enum logic [1:0] {
        BYTE_LOW,
        BYTE_HIGH,
        BYTE_UPPER
    } byte_select_t;

    typedef enum {
        LOCKED,
        FIRST_SEEN,
        UNLOCKED
    } unlock_state_t;

endpackage

// ### osc_tick_divider.sv
/*
  Divider standing in for the dedicated watchdog oscillator: one-cycle tick
  every OSC_TICK_CYCLES clocks, free running from reset.
  Assumes the system clock at the rate named in the package.
*/
`timescale 1ns/1ps
module osc_tick_divider
    import watchdog_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    output logic      tick
);

    typedef struct packed {
        logic [OSC_COUNT_WIDTH-1:0] count;
        logic                       tick;
    } div_state_t;

    div_state_t state;
    div_state_t next_state;

    always_comb
    begin
        next_state      = state;
        next_state.tick = 1'b0;
        if (state.count == OSC_COUNT_WIDTH'(OSC_TICK_CYCLES - 1))
        begin
            next_state.count = '0;
            next_state.tick  = 1'b1;
        end
        else
        begin
            next_state.count = state.count + OSC_COUNT_WIDTH'(1);
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

endmodule

// ### watchdog_unit.sv
/*
  Watchdog countdown unit with a two-key unlock sequence and a 24-bit
  reload value written one byte at a time.
  Holds the key sequencer, the reload bytes, the down counter and the
  one-cycle event outputs; a small divider supplies the slow count tick
  that stands in for the dedicated oscillator.
  Assumes software writes arrive as one-cycle strobes with byte data,
  synchronous to clock; no register bus, all controls are ports.
  Assumes enable and reset_mode are levels held by software between events.
  Refresh overrides a tick in the same cycle, so a refresh at zero raises
  no event. The low byte relocks, so it is written last; a later change
  needs the keys again.
*/
`timescale 1ns/1ps
module watchdog_unit
    import watchdog_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        enable,
    input  wire logic        reset_mode,
    input  wire logic        control_write,
    input  wire logic [7:0]  control_data,
    input  wire logic        upper_write,
    input  wire logic        high_write,
    input  wire logic        low_write,
    input  wire logic [7:0]  reload_data,
    input  wire logic        refresh,
    output logic             unlocked,
    output logic [23:0]      reload_value,
    output logic [23:0]      count,
    output logic             timeout_irq,
    output logic             system_reset
);

    // One struct holds all state; next_state is its combinational copy
    typedef struct packed {
        unlock_state_t    unlock;
        logic             unlocked;
        logic [23:0]      reload;
        logic [23:0]      count;
        logic             irq;
        logic             sys_reset;
    } wd_state_t;

    wd_state_t state;
    wd_state_t next_state;
    logic      osc_tick;
    logic      count_tick;
    logic      at_terminal;
    logic      reload_open;
    logic      fire_event;

    // Replace one byte of the reload value
    function automatic logic [23:0] put_byte(
        input logic [23:0]  value,
        input byte_select_t sel,
        input logic [7:0]   data
    );
        logic [23:0] result;
        result = value;
        case (sel)
            BYTE_LOW:   result[BYTE_LOW_POS +: 8]   = data;
            BYTE_HIGH:  result[BYTE_HIGH_POS +: 8]  = data;
            BYTE_UPPER: result[BYTE_UPPER_POS +: 8] = data;
            default:    result = value;
        endcase
        return result;
    endfunction

    // One step of the key sequence; off-pattern data relocks, a first key restarts
    function automatic unlock_state_t unlock_next(
        input unlock_state_t current,
        input logic [7:0]    data
    );
        unlock_state_t result;
        result = LOCKED;
        case (current)
            LOCKED:
            begin
                if (data == UNLOCK_FIRST)
                begin
                    result = FIRST_SEEN;
                end
            end
            FIRST_SEEN:
            begin
                if (data == UNLOCK_SECOND)
                begin
                    result = UNLOCKED;
                end
                else if (data == UNLOCK_FIRST)
                begin
                    result = FIRST_SEEN;
                end
            end
            UNLOCKED:
            begin
                if (data == UNLOCK_FIRST)
                begin
                    result = FIRST_SEEN;
                end
            end
            default:
            begin
                result = LOCKED;
            end
        endcase
        return result;
    endfunction

    osc_tick_divider tick_gen (
        .clock (clock),
        .rst_n (rst_n),
        .tick  (osc_tick)
    );

    // Ticks seen while disabled are lost, not queued
    assign count_tick  = enable && osc_tick;
    assign at_terminal = (state.count == COUNT_TERMINAL);
    // Control write wins, so a key byte never lands in the reload
    assign reload_open = (state.unlock == UNLOCKED) && !control_write;
    // A refresh in the terminal cycle wins and no event is raised
    assign fire_event  = count_tick && at_terminal && !refresh;

    always_comb
    begin
        next_state           = state;
        next_state.irq       = 1'b0;
        next_state.sys_reset = 1'b0;

        // Key sequence
        if (control_write)
        begin
            next_state.unlock = unlock_next(state.unlock, control_data);
        end

        // Locked-out writes are dropped silently
        if (reload_open)
        begin
            if (upper_write)
            begin
                next_state.reload = put_byte(next_state.reload, BYTE_UPPER, reload_data);
            end
            if (high_write)
            begin
                next_state.reload = put_byte(next_state.reload, BYTE_HIGH, reload_data);
            end
            if (low_write)
            begin
                next_state.reload = put_byte(next_state.reload, BYTE_LOW, reload_data);
                // Low byte closes the sequence, guarding against stray writes
                next_state.unlock = LOCKED;
            end
        end

        // Countdown
        if (refresh)
        begin
            next_state.count = state.reload;
        end
        else if (count_tick)
        begin
            if (at_terminal)
            begin
                next_state.count = state.reload;
            end
            else
            begin
                next_state.count = state.count - 24'h000001;
            end
        end

        // Event routed by mode, one cycle wide
        if (fire_event)
        begin
            if (reset_mode)
            begin
                next_state.sys_reset = 1'b1;
            end
            else
            begin
                next_state.irq = 1'b1;
            end
        end

        // Status comes from a flop rather than a decode of the state
        next_state.unlocked = (next_state.unlock == UNLOCKED);
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state.unlock    <= LOCKED;
            state.unlocked  <= 1'b0;
            state.reload    <= RELOAD_RESET;
            state.count     <= RELOAD_RESET;
            state.irq       <= 1'b0;
            state.sys_reset <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Outputs straight from the state register
    assign unlocked     = state.unlocked;
    assign reload_value = state.reload;
    assign count        = state.count;
    assign timeout_irq  = state.irq;
    assign system_reset = state.sys_reset;

endmodule

// ### watchdog_unit_asserts.sv
/* Port assertions for watchdog_unit.
   Assumes it is bound to every watchdog_unit instance. */
`timescale 1ns/1ps
module watchdog_unit_asserts (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        reset_mode,
    input wire logic        control_write,
    input wire logic [7:0]  control_data,
    input wire logic        upper_write,
    input wire logic [7:0]  reload_data,
    input wire logic        refresh,
    input wire logic        unlocked,
    input wire logic [23:0] reload_value,
    input wire logic [23:0] count,
    input wire logic        timeout_irq,
    input wire logic        system_reset
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    chk_unlock_cause: assert property ($rose(unlocked) |-> $past(control_write && control_data == 8'hAA))
        else $error("unlocked without second key");
    chk_locked_refused: assert property (!unlocked && upper_write && !control_write |=> $stable(reload_value))
        else $error("reload changed while locked");
    chk_upper_load: assert property (unlocked && upper_write && !control_write
        |=> reload_value[23:16] == $past(reload_data))
        else $error("upper reload byte not taken");
    chk_count_step: assert property ($changed(count) && !$past(refresh) && $past(count) != 24'h000000
        |-> count == $past(count) - 24'h000001)
        else $error("count moved other than down by one");
    chk_term_cause: assert property (timeout_irq || system_reset
        |-> $past(count, 1) == 24'h000000 || $past(count, 2) == 24'h000000)
        else $error("event without terminal count");
    chk_pulse_once: assert property (timeout_irq || system_reset |=> !timeout_irq && !system_reset)
        else $error("event longer than one cycle");
    chk_mode_route: assert property ((timeout_irq |-> !$past(reset_mode)) and (system_reset |-> $past(reset_mode)))
        else $error("event on wrong output");
    chk_reload_term: assert property ($past(count) == 24'h000000 && count != 24'h000000
        |-> count == $past(reload_value))
        else $error("count not reloaded after terminal");
    cover property ($rose(unlocked));
    cover property (timeout_irq);
    cover property (system_reset);
endmodule
bind watchdog_unit watchdog_unit_asserts chk (.clock, .rst_n, .reset_mode, .control_write, .control_data,
    .upper_write, .reload_data, .refresh, .unlocked, .reload_value, .count, .timeout_irq, .system_reset);

// ### watchdog_unit_tb_top.sv
/* Self-checking bench for watchdog_unit.
   Assumes the package tick period of 1000 clocks. */
`timescale 1ns/1ps
module watchdog_unit_tb_top;
    logic        clock = 1'b0, rst_n = 1'b0, enable = 1'b1, reset_mode = 1'b0, refresh = 1'b0;
    logic        control_write = 1'b0, upper_write = 1'b0, high_write = 1'b0, low_write = 1'b0;
    logic [7:0]  control_data = 8'h00, reload_data = 8'h00;
    logic        unlocked, timeout_irq, system_reset;
    logic [23:0] reload_value, count;
    int          num_errors = 0, tests_run = 0, cycles = 0;

    watchdog_unit dut (.clock(clock), .rst_n(rst_n), .enable(enable), .reset_mode(reset_mode),
        .control_write(control_write), .control_data(control_data), .upper_write(upper_write),
        .high_write(high_write), .low_write(low_write), .reload_data(reload_data), .refresh(refresh),
        .unlocked(unlocked), .reload_value(reload_value), .count(count), .timeout_irq(timeout_irq),
        .system_reset(system_reset));

    initial
    begin
        forever #5 clock = ~clock;
    end

    // Two events and the hold need about 7100 cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            finish_test();
        end
    end

    task finish_test();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task cmp(input string name, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Kinds: 0 control, 1 upper, 2 high, 3 low, 4 idle, 5 refresh; held so writes go back to back
    task wr(input int k, input logic [7:0] d);
        @(posedge clock);
        control_write <= (k == 0);
        upper_write   <= (k == 1);
        high_write    <= (k == 2);
        low_write     <= (k == 3);
        refresh       <= (k == 5);
        control_data  <= d;
        reload_data   <= d;
    endtask

    task wait_event(input logic sys);
        int i;
        i = 0;
        while (i < 4000 && (sys ? system_reset : timeout_irq) !== 1'b1)
        begin
            @(posedge clock);
            #1;
            i++;
        end
        cmp("event seen", 24'h000001, {23'h0, i < 4000});
        cmp("slow tick", 24'h000001, {23'h0, i > 1900});
        cmp("count reloaded", 24'h000002, count);
    endtask

    task check_reset();
        @(posedge clock);
        #1;
        cmp("reload_value", 24'hFFFFFF, reload_value);
        cmp("count", 24'hFFFFFF, count);
        cmp("unlocked", 24'h000000, {23'h0, unlocked});
    endtask

    task check_bad_order();
        wr(0, 8'hAA);
        wr(0, 8'h55);
        wr(1, 8'h12);
        wr(2, 8'h34);
        wr(3, 8'h56);
        wr(4, 8'h00);
        #1;
        cmp("reversed keys", 24'h000000, {23'h0, unlocked});
        cmp("locked write", 24'hFFFFFF, reload_value);
        wr(0, 8'h55);
        wr(0, 8'h12);
        wr(0, 8'hAA);
        wr(4, 8'h00);
        #1;
        cmp("broken keys", 24'h000000, {23'h0, unlocked});
    endtask

    task check_walk();
        wr(0, 8'h55);
        wr(0, 8'hAA);
        wr(1, 8'h01);
        #1;
        cmp("unlocked", 24'h000001, {23'h0, unlocked});
        wr(2, 8'h23);
        wr(3, 8'h45);
        wr(4, 8'h00);
        #1;
        cmp("reload_value", 24'h012345, reload_value);
        cmp("relocked", 24'h000000, {23'h0, unlocked});
    endtask

    task check_countdown();
        wr(0, 8'h55);
        wr(0, 8'hAA);
        wr(1, 8'h00);
        wr(2, 8'h00);
        wr(3, 8'h02);
        wr(5, 8'h00);
        wr(4, 8'h00);
        #1;
        cmp("count", 24'h000002, count);
        wait_event(1'b0);
        @(posedge clock);
        reset_mode <= 1'b1;
        wait_event(1'b1);
    endtask

    // Enable low must freeze the count across a tick
    task check_hold();
        @(posedge clock);
        enable <= 1'b0;
        repeat (1100) @(posedge clock);
        #1;
        cmp("held count", 24'h000002, count);
        @(posedge clock);
        enable <= 1'b1;
    endtask

    initial
    begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        check_reset();
        check_bad_order();
        check_walk();
        check_countdown();
        check_hold();
        finish_test();
    end
endmodule
